// file: verilog/ptp_receive_timestamp_filter.sv
// Purpose: Decides whether a received timing event message earns a timestamp
// Assumes: Message fields arrive parsed, one message per msg_valid pulse
// Notes: APB slave, zero wait states, registers at four times their index
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Domain enable requires domain number match
// - Alternate flag set skips timestamp when enabled
// - Half select steers address data writes
// - Custom address enable matches programmed destination
// - Slave only rejects control field one
// - Three enables for standard multicast groups
// - Bit 7 detects Ethernet carried messages
// - Bit 6 detects UDP over IPv6
// - Bit 5 detects UDP over IPv4
// - Version field restricts capture, zero disables
// - Capture only while receive enable set
// - First octet compared under mask bits
// - All zero mask disables octet filter
// - Address data read returns selected half
// - Domain value byte, resets to zero
//////////////////////////////////////////////////////////////////////////////
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module ptp_receive_timestamp_filter (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptp_rx_filter_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic msg_valid,
  input wire ptp_rx_filter_pkg::encap_t msg_encap,
  input wire logic [7:0] msg_first_octet,
  input wire logic [3:0] msg_version,
  input wire logic [7:0] msg_domain,
  input wire logic msg_alt_master,
  input wire logic [7:0] msg_control,
  input wire logic [31:0] msg_dst_addr,
  output logic capture,
  output logic reject
);
  import ptp_rx_filter_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] config_q;
  logic [15:0] octet_q;
  logic [31:0] ip_addr_q;
  logic [7:0] domain_q;
  logic [7:0] cap_count_q;
  logic last_pass_q;
  logic capture_q;
  logic reject_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic mapped;
  logic access;
  logic wr_en;

  logic [3:0] ver_sel;
  logic [7:0] oct_mask;
  logic [7:0] oct_value;
  assign ver_sel = config_q[VER_LSB +: 4];
  assign oct_mask = octet_q[MASK_LSB +: 8];
  assign oct_value = octet_q[VALUE_LSB +: 8];

  //////////////////////////////////////////////////////////////////////////
  // APB slave
  always_comb begin
    mapped = 1'b1;
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      ADDR_CONFIG: rdata_d[15:0] = config_q;
      ADDR_FIRST_OCTET: rdata_d[15:0] = octet_q;
      ADDR_ADDR_HALF: begin
        // Reads follow the current half select
        rdata_d[15:0] = config_q[BIT_HALF_SEL] ? ip_addr_q[15:0] : ip_addr_q[31:16];
      end
      ADDR_EXT: rdata_d[7:0] = domain_q;
      ADDR_STATUS: rdata_d[15:0] = {cap_count_q, 7'h00, last_pass_q};
      default: mapped = 1'b0;
    endcase
  end

  assign access = psel && penable;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign wr_en = access && pwrite && mapped;
  assign prdata = prdata_q;

  // Read data latched in setup so it leaves a flip-flop in the access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      config_q <= CONFIG_RST;
    end else if (wr_en && paddr == ADDR_CONFIG) begin
      config_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      octet_q <= FIRST_OCTET_RST;
    end else if (wr_en && paddr == ADDR_FIRST_OCTET) begin
      octet_q <= pwdata[15:0];
    end
  end

  // Upper half holds the earlier dotted octets
  always_ff @(posedge clk) begin
    if (rst) begin
      ip_addr_q <= ADDR_RST;
    end else if (wr_en && paddr == ADDR_ADDR_HALF) begin
      if (config_q[BIT_HALF_SEL]) begin
        ip_addr_q[15:0] <= pwdata[15:0];
      end else begin
        ip_addr_q[31:16] <= pwdata[15:0];
      end
    end
  end

  // Other bits of the extended register are not kept and read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      domain_q <= DOMAIN_RST;
    end else if (wr_en && paddr == ADDR_EXT) begin
      domain_q <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Message checks
  logic is_udp;
  logic addr_hit;
  logic encap_ok;
  logic addr_ok;
  logic ver_ok;
  logic dom_ok;
  logic alt_ok;
  logic ctl_ok;
  logic oct_ok;
  logic pass_all;
  logic [7:0] oct_miss;

  assign is_udp = msg_encap == ENC_UDP4 || msg_encap == ENC_UDP6;

  dest_address_match dest_address_match_inst (
    .is_v6(msg_encap == ENC_UDP6),
    .dst_addr(msg_dst_addr),
    .std_enables(config_q[STD_MC_LSB +: 3]),
    .custom_en(config_q[BIT_CUSTOM_EN]),
    .custom_addr(ip_addr_q),
    .hit(addr_hit)
  );

  // Only masked bit positions may miss
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_oct
      assign oct_miss[gi] = oct_mask[gi] && (msg_first_octet[gi] != oct_value[gi]);
    end
  endgenerate

  always_comb begin
    encap_ok = (msg_encap == ENC_ETH && config_q[BIT_ETH_EN])
      || (msg_encap == ENC_UDP6 && config_q[BIT_UDP6_EN])
      || (msg_encap == ENC_UDP4 && config_q[BIT_UDP4_EN]);
    // Ethernet carried messages have no IP address to filter
    addr_ok = !is_udp || addr_hit;
    ver_ok = ver_sel == 4'h0 || msg_version == ver_sel;
    dom_ok = !config_q[BIT_DOMAIN_EN] || msg_domain == domain_q;
    alt_ok = !(config_q[BIT_ALT_SKIP] && msg_alt_master);
    ctl_ok = !(config_q[BIT_SLAVE_ONLY] && msg_control == DELAY_REQ_CTRL);
    oct_ok = oct_miss == 8'h00;
    pass_all = config_q[BIT_CAPTURE_EN] && encap_ok && addr_ok && ver_ok
      && dom_ok && alt_ok && ctl_ok && oct_ok;
  end

  //////////////////////////////////////////////////////////////////////////
  // Decision outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      capture_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      capture_q <= msg_valid && pass_all;
      reject_q <= msg_valid && !pass_all;
    end
  end

  // Counter wraps; software reads differences
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_count_q <= 8'h00;
      last_pass_q <= 1'b0;
    end else if (msg_valid) begin
      last_pass_q <= pass_all;
      if (pass_all) begin
        cap_count_q <= cap_count_q + 8'h01;
      end
    end
  end

  assign capture = capture_q;
  assign reject = reject_q;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_msg;
    msg_valid;
  endsequence

  sequence s_refused;
    !capture_q && reject_q;
  endsequence

  property p_domain;
    s_msg and config_q[BIT_DOMAIN_EN] && msg_domain != domain_q |=> s_refused;
  endproperty
  a_domain: assert property (p_domain) else $error("domain mismatch captured");

  property p_alt;
    s_msg and config_q[BIT_ALT_SKIP] && msg_alt_master |=> s_refused;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate flag captured");

  property p_half_write;
    wr_en && paddr == ADDR_ADDR_HALF && !config_q[BIT_HALF_SEL]
      |=> ip_addr_q[31:16] == $past(pwdata[15:0]) && $stable(ip_addr_q[15:0]);
  endproperty
  a_half_write: assert property (p_half_write) else $error("upper half write wrong");

  property p_half_read;
    psel && !penable && !pwrite && paddr == ADDR_ADDR_HALF
      |=> prdata[15:0] == ($past(config_q[BIT_HALF_SEL]) ? $past(ip_addr_q[15:0])
        : $past(ip_addr_q[31:16])) && prdata[31:16] == 16'h0000;
  endproperty
  a_half_read: assert property (p_half_read) else $error("address half read wrong");

  property p_custom_hit;
    msg_encap == ENC_UDP4 && config_q[BIT_CUSTOM_EN] && msg_dst_addr == ip_addr_q
      |-> addr_hit;
  endproperty
  a_custom_hit: assert property (p_custom_hit) else $error("custom address miss");

  property p_slave;
    s_msg and config_q[BIT_SLAVE_ONLY] && msg_control == DELAY_REQ_CTRL |=> s_refused;
  endproperty
  a_slave: assert property (p_slave) else $error("delay request captured");

  property p_std_group;
    s_msg and msg_encap == ENC_UDP4 && !config_q[BIT_CUSTOM_EN]
      && config_q[STD_MC_LSB +: 3] == 3'h0 |=> s_refused;
  endproperty
  a_std_group: assert property (p_std_group) else $error("unfiltered address captured");

  property p_encap;
    s_msg and ((msg_encap == ENC_ETH && !config_q[BIT_ETH_EN])
      || (msg_encap == ENC_UDP6 && !config_q[BIT_UDP6_EN])
      || (msg_encap == ENC_UDP4 && !config_q[BIT_UDP4_EN])) |=> s_refused;
  endproperty
  a_encap: assert property (p_encap) else $error("disabled encap captured");

  property p_version;
    s_msg and ver_sel != 4'h0 && msg_version != ver_sel |=> s_refused;
  endproperty
  a_version: assert property (p_version) else $error("version mismatch captured");

  property p_enable;
    !config_q[BIT_CAPTURE_EN] |=> !capture_q;
  endproperty
  a_enable: assert property (p_enable) else $error("capture while disabled");

  property p_octet;
    s_msg and ((msg_first_octet ^ oct_value) & oct_mask) != 8'h00 |=> s_refused;
  endproperty
  a_octet: assert property (p_octet) else $error("first octet mismatch captured");

  property p_octet_off;
    oct_mask == 8'h00 |-> oct_ok;
  endproperty
  a_octet_off: assert property (p_octet_off) else $error("zero mask still filters");

  property p_domain_write;
    wr_en && paddr == ADDR_EXT |=> domain_q == $past(pwdata[7:0]);
  endproperty
  a_domain_write: assert property (p_domain_write) else $error("domain value lost");

  property p_all_pass;
    s_msg and pass_all |=> capture_q && !reject_q
      && cap_count_q == $past(cap_count_q) + 8'h01;
  endproperty
  a_all_pass: assert property (p_all_pass) else $error("passing message not captured");

  property p_no_spurious;
    !msg_valid |=> !capture_q && !reject_q;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("decision without message");

  // Counter moves only on a passing message
  property p_count_hold;
    !msg_valid |=> $stable(cap_count_q);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("count moved idle");

  property p_refused_count;
    s_msg and !pass_all |=> $stable(cap_count_q) && !last_pass_q;
  endproperty
  a_refused_count: assert property (p_refused_count) else $error("refusal counted");

  property p_one_answer;
    s_msg |=> capture_q != reject_q;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("not one answer");

  property p_low_half;
    wr_en && paddr == ADDR_ADDR_HALF && config_q[BIT_HALF_SEL]
      |=> ip_addr_q[15:0] == $past(pwdata[15:0]) && $stable(ip_addr_q[31:16]);
  endproperty
  a_low_half: assert property (p_low_half) else $error("lower half write wrong");

  property p_config_write;
    wr_en && paddr == ADDR_CONFIG |=> config_q == $past(pwdata[15:0]);
  endproperty
  a_config_write: assert property (p_config_write) else $error("config not stored");

  property p_octet_write;
    wr_en && paddr == ADDR_FIRST_OCTET |=> octet_q == $past(pwdata[15:0]);
  endproperty
  a_octet_write: assert property (p_octet_write) else $error("octet match not stored");

  // IPv6 needs an enabled address filter as well
  property p_v6_group;
    s_msg and msg_encap == ENC_UDP6 && !config_q[BIT_CUSTOM_EN]
      && config_q[STD_MC_LSB +: 3] == 3'h0 |=> s_refused;
  endproperty
  a_v6_group: assert property (p_v6_group) else $error("unfiltered v6 captured");
endmodule // ptp_receive_timestamp_filter

// file: verilog/ptp_rx_filter_pkg.sv
// Purpose: Shared constants and types of the receive timestamp filter
// Assumes: 32-bit APB, register index times four gives the byte address
// Notes: All configuration resets to zero
package ptp_rx_filter_pkg;
  localparam int unsigned AW = 12;
  localparam logic [7:0] IDX_CONFIG = 8'h19;
  localparam logic [7:0] IDX_FIRST_OCTET = 8'h1A;
  localparam logic [7:0] IDX_ADDR_HALF = 8'h1B;
  localparam logic [7:0] IDX_EXT = 8'h1C;
  localparam logic [7:0] IDX_STATUS = 8'h1E;
  localparam logic [AW-1:0] ADDR_CONFIG = {2'b00, IDX_CONFIG, 2'b00};
  localparam logic [AW-1:0] ADDR_FIRST_OCTET = {2'b00, IDX_FIRST_OCTET, 2'b00};
  localparam logic [AW-1:0] ADDR_ADDR_HALF = {2'b00, IDX_ADDR_HALF, 2'b00};
  localparam logic [AW-1:0] ADDR_EXT = {2'b00, IDX_EXT, 2'b00};
  localparam logic [AW-1:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};
  // Config bit positions
  localparam int unsigned BIT_DOMAIN_EN = 15;
  localparam int unsigned BIT_ALT_SKIP = 14;
  localparam int unsigned BIT_HALF_SEL = 13;
  localparam int unsigned BIT_CUSTOM_EN = 12;
  localparam int unsigned BIT_SLAVE_ONLY = 11;
  localparam int unsigned STD_MC_LSB = 8;
  localparam int unsigned BIT_ETH_EN = 7;
  localparam int unsigned BIT_UDP6_EN = 6;
  localparam int unsigned BIT_UDP4_EN = 5;
  localparam int unsigned VER_LSB = 1;
  localparam int unsigned BIT_CAPTURE_EN = 0;
  localparam int unsigned MASK_LSB = 8;
  localparam int unsigned VALUE_LSB = 0;
  // Reset values
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [15:0] FIRST_OCTET_RST = 16'h0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [7:0] DOMAIN_RST = 8'h00;
  // Standard multicast groups, IPv4 whole and IPv6 low 16 bits
  localparam logic [31:0] V4_PRIMARY = 32'hE000_0181;
  localparam logic [31:0] V4_ALT_FIRST = 32'hE000_0182;
  localparam logic [31:0] V4_ALT_LAST = 32'hE000_0184;
  localparam logic [31:0] V4_PEER = 32'hE000_006B;
  localparam logic [15:0] V6_PRIMARY = 16'h0181;
  localparam logic [15:0] V6_ALT_FIRST = 16'h0182;
  localparam logic [15:0] V6_ALT_LAST = 16'h0184;
  localparam logic [15:0] V6_PEER = 16'h006B;
  localparam logic [7:0] DELAY_REQ_CTRL = 8'h01;
  typedef enum logic [3:0] {
    ENC_NONE = 4'b0001,
    ENC_ETH = 4'b0010,
    ENC_UDP4 = 4'b0100,
    ENC_UDP6 = 4'b1000
  } encap_t;
endpackage

// file: verilog/dest_address_match.sv
// Purpose: Destination address filter for UDP carried timing messages
// Assumes: IPv6 groups are told apart by the low 16 address bits
// Notes: Purely combinational
`timescale 1ns/1ns
module dest_address_match (
  input wire logic is_v6,
  input wire logic [31:0] dst_addr,
  input wire logic [2:0] std_enables,
  input wire logic custom_en,
  input wire logic [31:0] custom_addr,
  output logic hit
);
  import ptp_rx_filter_pkg::*;
  logic [2:0] std_hit;
  logic [15:0] low;
  always_comb begin
    low = dst_addr[15:0];
    if (is_v6) begin
      std_hit[0] = low == V6_PRIMARY;
      std_hit[1] = low >= V6_ALT_FIRST && low <= V6_ALT_LAST;
      std_hit[2] = low == V6_PEER;
    end else begin
      std_hit[0] = dst_addr == V4_PRIMARY;
      std_hit[1] = dst_addr >= V4_ALT_FIRST && dst_addr <= V4_ALT_LAST;
      std_hit[2] = dst_addr == V4_PEER;
    end
    hit = |(std_hit & std_enables) || (custom_en && dst_addr == custom_addr);
  end
endmodule // dest_address_match

// file: testbench/msg_source.sv
// Purpose: Remote station model that hands parsed event messages to the filter
// Assumes: One message per call, fields valid only in the msg_valid cycle
// Notes: Fields other than msg_encap are inverted once released so stale values never match; msg_encap returns to ENC_NONE
`timescale 1ns/1ns
module msg_source (
  input wire logic clk,
  output logic msg_valid,
  output ptp_rx_filter_pkg::encap_t msg_encap,
  output logic [7:0] msg_first_octet,
  output logic [3:0] msg_version,
  output logic [7:0] msg_domain,
  output logic msg_alt_master,
  output logic [7:0] msg_control,
  output logic [31:0] msg_dst_addr
);
  import ptp_rx_filter_pkg::*;
  initial begin
    msg_valid = 1'b0;
    msg_encap = ENC_NONE;
    msg_first_octet = 8'h00;
    msg_version = 4'h0;
    msg_domain = 8'h00;
    msg_alt_master = 1'b0;
    msg_control = 8'h00;
    msg_dst_addr = 32'h0000_0000;
  end
  task send(input encap_t e, input logic [7:0] o, input logic [3:0] v, input logic [7:0] d,
            input logic al, input logic [7:0] c, input logic [31:0] a);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_encap <= e;
    msg_first_octet <= o;
    msg_version <= v;
    msg_domain <= d;
    msg_alt_master <= al;
    msg_control <= c;
    msg_dst_addr <= a;
    @(posedge clk);
    msg_valid <= 1'b0;
    msg_encap <= ENC_NONE;
    msg_first_octet <= ~o;
    msg_version <= ~v;
    msg_domain <= ~d;
    msg_alt_master <= ~al;
    msg_control <= ~c;
    msg_dst_addr <= ~a;
  endtask
endmodule // msg_source

// file: testbench/ptp_receive_timestamp_filter_tb.sv
// Purpose: Self-checking bench of the receive timestamp filter
// Assumes: Zero wait state APB, answer one cycle after msg_valid
// Notes: One idle cycle between transfers keeps the drivers simple
`timescale 1ns/1ns
module ptp_receive_timestamp_filter_tb_top;
  import ptp_rx_filter_pkg::*;
  // Capture on, all encapsulations, version 2
  localparam logic [31:0] BASE = 32'h0000_00E5;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic msg_valid, msg_alt_master, capture, reject, m_alt;
  encap_t msg_encap;
  logic [7:0] msg_first_octet, msg_domain, msg_control, m_oct, m_dom, m_ctl;
  logic [3:0] msg_version, m_ver;
  logic [31:0] msg_dst_addr;
  int bad_count, comparisons;
  ptp_receive_timestamp_filter ptp_receive_timestamp_filter_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .msg_valid(msg_valid), .msg_encap(msg_encap),
    .msg_first_octet(msg_first_octet), .msg_version(msg_version),
    .msg_domain(msg_domain), .msg_alt_master(msg_alt_master),
    .msg_control(msg_control), .msg_dst_addr(msg_dst_addr),
    .capture(capture), .reject(reject));
  msg_source msg_source_inst (
    .clk(clk), .msg_valid(msg_valid), .msg_encap(msg_encap),
    .msg_first_octet(msg_first_octet), .msg_version(msg_version),
    .msg_domain(msg_domain), .msg_alt_master(msg_alt_master),
    .msg_control(msg_control), .msg_dst_addr(msg_dst_addr));
  //////////////////////////////////////////////////////////////////////////////
  task stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd, exp);
  endtask
  // Default message fields: version 2, domain 0, flags clear
  task base();
    m_oct = 8'h00;
    m_ver = 4'h2;
    m_dom = 8'h00;
    m_alt = 1'b0;
    m_ctl = 8'h00;
  endtask
  task ck(input encap_t e, input logic [31:0] a, input logic exp);
    msg_source_inst.send(e, m_oct, m_ver, m_dom, m_alt, m_ctl, a);
    #1;
    cmp({capture, reject}, {exp, !exp});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_reset();
    base();
    rc(ADDR_CONFIG, 32'h0000_0000);
    rc(ADDR_FIRST_OCTET, 32'h0000_0000);
    rc(ADDR_ADDR_HALF, 32'h0000_0000);
    rc(ADDR_EXT, 32'h0000_0000);
    wr(ADDR_STATUS, 32'h0000_FFFF);
    cmp(err, 1'b0);
    apb(1'b0, 12'h000, 32'h0000_0000);
    cmp(err, 1'b1);
    ck(ENC_ETH, V4_PRIMARY, 1'b0);
    rc(ADDR_STATUS, 32'h0000_0000);
    $display("test reset done");
  endtask
  task t_addr();
    wr(ADDR_CONFIG, BASE);
    wr(ADDR_ADDR_HALF, 32'hFFFF_E000);
    wr(ADDR_CONFIG, BASE | 32'h3000);
    wr(ADDR_ADDR_HALF, 32'h0000_0181);
    rc(ADDR_ADDR_HALF, 32'h0000_0181);
    ck(ENC_UDP4, 32'hE000_0181, 1'b1);
    rc(ADDR_STATUS, 32'h0000_0101);
    ck(ENC_UDP4, 32'h0181_E000, 1'b0);
    rc(ADDR_STATUS, 32'h0000_0100);
    ck(ENC_UDP6, 32'hE000_0181, 1'b1);
    wr(ADDR_CONFIG, BASE | 32'h1000);
    rc(ADDR_ADDR_HALF, 32'h0000_E000);
    wr(ADDR_CONFIG, BASE);
    ck(ENC_UDP4, 32'hE000_0181, 1'b0);
    ck(ENC_UDP6, 32'hE000_0181, 1'b0);
    $display("test address done");
  endtask
  task t_encap();
    encap_t enc [3];
    int bitp [3];
    enc = '{ENC_ETH, ENC_UDP4, ENC_UDP6};
    bitp = '{7, 5, 6};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONFIG, 32'h0000_0105 | (32'h1 << bitp[i]));
      for (int j = 0; j < 3; j++)
        ck(enc[j], V4_PRIMARY, i == j);
    end
    wr(ADDR_CONFIG, BASE & 32'hFFFF_FFFE);
    ck(ENC_ETH, V4_PRIMARY, 1'b0);
    $display("test encapsulation done");
  endtask
  task t_groups();
    logic [31:0] adr [5];
    int grp [5];
    adr = '{V4_PRIMARY, V4_ALT_FIRST, V4_ALT_LAST, V4_PEER, 32'hE000_0185};
    grp = '{0, 1, 1, 2, 3};
    for (int g = 0; g < 3; g++) begin
      wr(ADDR_CONFIG, BASE | (32'h100 << g));
      for (int k = 0; k < 5; k++) begin
        ck(ENC_UDP4, adr[k], grp[k] == g);
        ck(ENC_UDP6, adr[k], grp[k] == g);
      end
    end
    $display("test groups done");
  endtask
  task t_fields();
    wr(ADDR_CONFIG, BASE);
    m_ver = 4'h3;
    ck(ENC_ETH, 32'h0, 1'b0);
    wr(ADDR_CONFIG, BASE & 32'hFFFF_FFE1);
    ck(ENC_ETH, 32'h0, 1'b1);
    base();
    wr(ADDR_EXT, 32'h0000_0105);
    rc(ADDR_EXT, 32'h0000_0005);
    wr(ADDR_CONFIG, BASE | 32'h8000);
    m_dom = 8'h04;
    ck(ENC_ETH, 32'h0, 1'b0);
    m_dom = 8'h05;
    ck(ENC_ETH, 32'h0, 1'b1);
    m_alt = 1'b1;
    ck(ENC_ETH, 32'h0, 1'b1);
    wr(ADDR_CONFIG, BASE | 32'h4000);
    ck(ENC_ETH, 32'h0, 1'b0);
    m_alt = 1'b0;
    m_dom = 8'h04;
    m_ctl = 8'h01;
    ck(ENC_ETH, 32'h0, 1'b1);
    wr(ADDR_CONFIG, BASE | 32'h0800);
    ck(ENC_ETH, 32'h0, 1'b0);
    m_ctl = 8'h02;
    ck(ENC_ETH, 32'h0, 1'b1);
    wr(ADDR_FIRST_OCTET, 32'h0000_F00A);
    m_oct = 8'h05;
    ck(ENC_ETH, 32'h0, 1'b1);
    m_oct = 8'h15;
    ck(ENC_ETH, 32'h0, 1'b0);
    wr(ADDR_FIRST_OCTET, 32'h0000_00FF);
    rc(ADDR_FIRST_OCTET, 32'h0000_00FF);
    ck(ENC_ETH, 32'h0, 1'b1);
    $display("test fields done");
  endtask
  // Reset in mid run must return the config, first octet, extended and status registers to zero
  task t_midreset();
    wr(ADDR_FIRST_OCTET, 32'h0000_F00A);
    wr(ADDR_EXT, 32'h0000_0007);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(ADDR_CONFIG, 32'h0000_0000);
    rc(ADDR_FIRST_OCTET, 32'h0000_0000);
    rc(ADDR_EXT, 32'h0000_0000);
    rc(ADDR_STATUS, 32'h0000_0000);
    ck(ENC_ETH, 32'h0, 1'b0);
    $display("test mid reset done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
    bad_count = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_addr();
    t_encap();
    t_groups();
    t_fields();
    t_midreset();
    stop_test();
  end
endmodule // ptp_receive_timestamp_filter_tb_top
